// >>> core/dpo_rx_out.sv
// Purpose: receiver output end: lane capture, 8-word buffer, pixel bus launch
// Assumes: lane data changes away from the rising edge of clock_lane_input
// Notes:   output clock is gapped: it only runs while buffered pixels exist
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// synchronous fifo, depth must be a power of two
// ------------------------------------------------------------------
module dpo_fifo #(
  parameter int W     = 30,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } dpo_fifo_st_t;
  dpo_fifo_st_t st_reg, st_next;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((st_reg.wp[AW] != st_reg.rp[AW]) &&
                       (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]));
  assign out_valid = (st_reg.wp != st_reg.rp);
  assign out_data  = st_reg.mem[st_reg.rp[AW-1:0]];

  // pointer and storage update
  always_comb begin
    st_next = st_reg;
    if (in_valid && in_ready) begin
      st_next.mem[st_reg.wp[AW-1:0]] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (out_valid && out_ready) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end
endmodule

// Behaviour
// RULE1 - even bus red on bits 16-23
// RULE2 - two-pixel mode: odd pixel on odd bus
// RULE3 - one-pixel mode: odd bus held low
// RULE4 - bus outputs change with output pixel clock
// RULE5 - lane zero: blue, line/frame sync in blanking
// RULE6 - lane one: green, control bit one in blanking
// RULE7 - lane two: red, control bits two, three
// RULE8 - link flag high while enable keeps toggling
// RULE9 - board may tie link flag to power gate
// RULE10 - skew low in two-pixel mode: stagger buses
// RULE11 - skew high: even and odd together
// RULE12 - select high two pixels, low one pixel
// RULE13 - one-pixel mode: sequential on even bus, even first
// RULE14 - edge select high rising latch, low falling
// RULE15 - output clock one or two pixel times
// RULE16 - odd bus launched later within low phase
module dpo_rx_out #(
  parameter int HALF1     = dpo_pkg::ONE_PIX_HALF_CYC,
  parameter int HALF2     = dpo_pkg::TWO_PIX_HALF_CYC,
  parameter int IDLE_CYC  = dpo_pkg::LINK_IDLE_CYC,
  parameter int DEPTH     = dpo_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       ce,
  // decoded lanes from serial recovery
  input  wire logic       clock_lane_input,
  input  wire logic [7:0] lane_zero_input,
  input  wire logic [7:0] lane_one_input,
  input  wire logic [7:0] lane_two_input,
  input  wire logic       lane_enable_input,
  // status
  output logic            overflow,
  // panel pins
  dpo_link_if.dev         link
);
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int W  = dpo_pkg::WORD_W;

  typedef struct packed {
    logic                           lclk_s1;
    logic                           lclk_s2;
    logic                           lclk_s3;
    logic [dpo_pkg::RAW_W-1:0]      raw_s1;
    logic [dpo_pkg::RAW_W-1:0]      raw_s2;
    logic [3:0]                     cfg_s1;
    logic [3:0]                     cfg_s2;
    logic                           en_last;
    logic [IW-1:0]                  idle_cnt;
    logic                           link_act;
    logic [dpo_pkg::CTL_W-1:0]      ctl_hold;
    logic                           cap_valid;
    logic [W-1:0]                   cap_word;
    logic                           ovf;
    dpo_pkg::dpo_ostate_t           ost;
    logic [7:0]                     cnt;
    logic [W-1:0]                   ev_word;
    logic [W-1:0]                   od_word;
    logic [23:0]                    even_bus;
    logic [23:0]                    odd_bus;
    logic [dpo_pkg::CTL_W:0]        sync_out;  // {en, hs, vs, c1, c2, c3}
    logic                           clk_out;
  } dpo_dev_st_t;
  dpo_dev_st_t st_reg, st_next;

  logic         f_ready;
  logic         f_valid;
  logic         f_pop;
  logic [W-1:0] f_data;

  // cfg bit order: {gate, edge, skew_n, two_pix}
  logic       two_pix;
  logic       skew_n;
  logic       edge_r;
  logic       gate;
  logic [7:0] half;
  assign two_pix = st_reg.cfg_s2[0]; // RULE12
  assign skew_n  = st_reg.cfg_s2[1];
  assign edge_r  = st_reg.cfg_s2[2];
  assign gate    = st_reg.cfg_s2[3];
  assign half    = two_pix ? 8'(HALF2) : 8'(HALF1); // RULE15

  // pixel field of a word, blanking words carry no pixel
  function automatic logic [23:0] pix_of(input logic [W-1:0] w);
    pix_of = w[dpo_pkg::VID_BIT] ? w[dpo_pkg::PIX_W-1:0] : 24'h000000;
  endfunction

  dpo_fifo #(
    .W     (W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (st_reg.cap_valid),
    .in_ready  (f_ready),
    .in_data   (st_reg.cap_word),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
  );

  // pop once per pixel while idle or waiting for the odd half of a pair
  assign f_pop = f_valid && (st_reg.ost == dpo_pkg::S_IDLE || st_reg.ost == dpo_pkg::S_SECOND);

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    logic                    lane_edge;
    logic                    en_now;
    logic [dpo_pkg::RAW_W-1:0] r;
    logic [W-1:0]            w;
    lane_edge = 1'b0;
    en_now    = 1'b0;
    r         = '0;
    w         = '0;
    st_next   = st_reg;

    // pins pass two flops before use
    st_next.lclk_s1 = clock_lane_input;
    st_next.lclk_s2 = st_reg.lclk_s1;
    st_next.lclk_s3 = st_reg.lclk_s2;
    st_next.raw_s1  = {lane_enable_input, lane_two_input, lane_one_input, lane_zero_input};
    st_next.raw_s2  = st_reg.raw_s1;
    st_next.cfg_s1  = {link.output_power_gate, link.clock_edge_select,
                       link.skew_outputs_n, link.pixels_per_clock_select};
    st_next.cfg_s2  = st_reg.cfg_s1;

    // activity monitor: any enable change restarts the idle count
    r      = st_reg.raw_s2;
    en_now = r[dpo_pkg::RAW_EN];
    st_next.en_last = en_now;
    if (en_now != st_reg.en_last) begin
      st_next.idle_cnt = '0; // RULE8
      st_next.link_act = 1'b1;
    end else if (st_reg.idle_cnt == IW'(IDLE_CYC - 1)) begin
      st_next.link_act = 1'b0; // RULE8
    end else begin
      st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
    end

    // capture one word per rising lane clock edge
    lane_edge = st_reg.lclk_s2 && !st_reg.lclk_s3;
    if (st_reg.cap_valid && f_ready) begin
      st_next.cap_valid = 1'b0;
    end
    if (lane_edge) begin
      w = '0;
      if (en_now) begin
        w[dpo_pkg::B_LSB +: 8] = r[dpo_pkg::RAW_L0_LSB +: 8]; // RULE5
        w[dpo_pkg::G_LSB +: 8] = r[dpo_pkg::RAW_L1_LSB +: 8]; // RULE6
        w[dpo_pkg::R_LSB +: 8] = r[dpo_pkg::RAW_L2_LSB +: 8]; // RULE7
      end else begin
        st_next.ctl_hold = {r[dpo_pkg::RAW_L0_LSB], r[dpo_pkg::RAW_L0_LSB + 1], // RULE5
                            r[dpo_pkg::RAW_L1_LSB],                             // RULE6
                            r[dpo_pkg::RAW_L2_LSB], r[dpo_pkg::RAW_L2_LSB + 1]}; // RULE7
      end
      w[dpo_pkg::C3_BIT:dpo_pkg::C3_BIT - 0] = st_next.ctl_hold[0];
      w[dpo_pkg::C2_BIT] = st_next.ctl_hold[1];
      w[dpo_pkg::C1_BIT] = st_next.ctl_hold[2];
      w[dpo_pkg::VS_BIT] = st_next.ctl_hold[3];
      w[dpo_pkg::HS_BIT] = st_next.ctl_hold[4];
      w[dpo_pkg::VID_BIT] = en_now;
      // a pending word not yet taken by the buffer is overwritten and flagged
      if (st_reg.cap_valid && !f_ready) begin
        st_next.ovf = 1'b1;
      end
      st_next.cap_word  = w;
      st_next.cap_valid = 1'b1;
    end

    // output launch sequencer
    case (st_reg.ost)
      dpo_pkg::S_IDLE: begin
        st_next.clk_out = edge_r; // parked at latch level
        st_next.odd_bus = two_pix ? st_reg.odd_bus : 24'h000000; // RULE3
        if (f_valid) begin
          st_next.ev_word = f_data; // RULE13
          st_next.od_word = '0;
          st_next.ost     = two_pix ? dpo_pkg::S_SECOND : dpo_pkg::S_LAUNCH;
        end
      end
      dpo_pkg::S_SECOND: begin
        if (f_valid) begin
          st_next.od_word = f_data;
          st_next.ost     = dpo_pkg::S_LAUNCH;
        end
      end
      dpo_pkg::S_LAUNCH: begin
        // launch edge is the opposite of the latch edge
        st_next.clk_out  = !edge_r; // RULE14
        st_next.cnt      = 8'h00;
        st_next.even_bus = gate ? pix_of(st_reg.ev_word) : 24'h000000; // RULE1 RULE4
        st_next.sync_out = gate ? st_reg.ev_word[W-1:dpo_pkg::PIX_W]
                                : {5'h00, st_reg.ev_word[dpo_pkg::C1_BIT]};
        if (!two_pix || !gate) begin
          st_next.odd_bus = 24'h000000; // RULE3
        end else if (skew_n) begin
          st_next.odd_bus = pix_of(st_reg.od_word); // RULE2 RULE11
        end
        st_next.ost = dpo_pkg::S_LOW;
      end
      dpo_pkg::S_LOW: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        // staggered odd bus moves half/2 + 1 core cycles after the even bus
        if (two_pix && !skew_n && gate && st_reg.cnt == (half >> 1)) begin
          st_next.odd_bus = pix_of(st_reg.od_word); // RULE10 RULE16
        end
        if (st_reg.cnt == half - 8'h01) begin
          st_next.clk_out = edge_r; // RULE14
          st_next.cnt     = 8'h00;
          st_next.ost     = dpo_pkg::S_HIGH;
        end
      end
      dpo_pkg::S_HIGH: begin
        st_next.cnt = st_reg.cnt + 8'h01;
        if (st_reg.cnt == half - 8'h01) begin
          st_next.ost = dpo_pkg::S_IDLE;
        end
      end
      default: begin
        st_next.ost = dpo_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= '0;
      st_reg.ost <= dpo_pkg::S_IDLE;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // --------------------------------------------------------------
  // pins
  // --------------------------------------------------------------
  assign link.even_pixel_bus      = st_reg.even_bus;
  assign link.odd_pixel_bus       = st_reg.odd_bus;
  assign link.output_pixel_clock  = st_reg.clk_out;
  assign link.active_video_enable = st_reg.sync_out[5];
  assign link.hsync               = st_reg.sync_out[4];
  assign link.vsync               = st_reg.sync_out[3];
  assign link.control_bit_one     = st_reg.sync_out[2];
  assign link.control_bit_two     = st_reg.sync_out[1];
  assign link.control_bit_three   = st_reg.sync_out[0];
  assign link.link_active_flag    = st_reg.link_act;
  assign overflow                 = st_reg.ovf;
endmodule
`default_nettype wire

// >>> core/dpo_pkg.sv
// Purpose: shared constants and types for the panel-side pixel output pair
// Assumes: 100 MHz core clock on both ends
// Notes:   word layouts are the only contract between capture and launch
package dpo_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS          = 10;
  localparam int ONE_PIX_HALF_NS = 60;     // half output clock, one pixel per clock
  localparam int TWO_PIX_HALF_NS = 120;    // half output clock, two pixels per clock
  localparam int LINK_IDLE_NS    = 100000; // no enable toggle for this long: link idle
  localparam int ONE_PIX_HALF_CYC = (ONE_PIX_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWO_PIX_HALF_CYC = (TWO_PIX_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINK_IDLE_CYC    = LINK_IDLE_NS / CLK_NS;
  localparam int FIFO_DEPTH       = 8;

  // ----------------------------------------------------------------
  // raw lane sample: {enable, lane two, lane one, lane zero}
  // ----------------------------------------------------------------
  localparam int RAW_W      = 25;
  localparam int RAW_L0_LSB = 0;
  localparam int RAW_L1_LSB = 8;
  localparam int RAW_L2_LSB = 16;
  localparam int RAW_EN     = 24;

  // ----------------------------------------------------------------
  // buffered word: {en, hs, vs, c1, c2, c3, red, green, blue}
  // ----------------------------------------------------------------
  localparam int WORD_W  = 30;
  localparam int B_LSB   = 0;
  localparam int G_LSB   = 8;
  localparam int R_LSB   = 16;
  localparam int C3_BIT  = 24;
  localparam int C2_BIT  = 25;
  localparam int C1_BIT  = 26;
  localparam int VS_BIT  = 27;
  localparam int HS_BIT  = 28;
  localparam int VID_BIT = 29;
  localparam int PIX_W   = 24;
  localparam int CTL_W   = 5;
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;

  typedef enum logic [2:0] {S_IDLE, S_SECOND, S_LAUNCH, S_LOW, S_HIGH} dpo_ostate_t;

endpackage

// >>> core/dpo_link_if.sv
// Purpose: panel-facing pins between receiver output end and panel end
// Assumes: both ends on their own 100 MHz clock
// Notes:   all signals are plain levels, no clocking block
`timescale 1ns/1ns
`default_nettype none
interface dpo_link_if;
  logic [23:0] even_pixel_bus;
  logic [23:0] odd_pixel_bus;
  logic        output_pixel_clock;
  logic        hsync;
  logic        vsync;
  logic        active_video_enable;
  logic        control_bit_one;
  logic        control_bit_two;
  logic        control_bit_three;
  logic        link_active_flag;
  logic        pixels_per_clock_select;
  logic        skew_outputs_n;
  logic        clock_edge_select;
  logic        output_power_gate;

  modport dev (
    output even_pixel_bus, odd_pixel_bus, output_pixel_clock, hsync, vsync,
    output active_video_enable, control_bit_one, control_bit_two,
    output control_bit_three, link_active_flag,
    input  pixels_per_clock_select, skew_outputs_n, clock_edge_select,
    input  output_power_gate
  );
  modport panel (
    input  even_pixel_bus, odd_pixel_bus, output_pixel_clock, hsync, vsync,
    input  active_video_enable, control_bit_one, control_bit_two,
    input  control_bit_three, link_active_flag,
    output pixels_per_clock_select, skew_outputs_n, clock_edge_select,
    output output_power_gate
  );
endinterface
`default_nettype wire

// >>> core/dpo_panel_sink.sv
// Purpose: panel end: straps the receiver modes and latches its pixel buses
// Assumes: output clock edges are at least two core cycles apart
// Notes:   all pins are foreign to this clock and pass two flops
`timescale 1ns/1ns
`default_nettype none
module dpo_panel_sink #(
  parameter bit TIE_GATE = 1'b1
) (
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  // mode straps
  input  wire logic        two_pixel_mode,
  input  wire logic        skew_n,
  input  wire logic        latch_rising,
  // captured pixels
  output logic [23:0]      even_pixel,
  output logic [23:0]      odd_pixel,
  output logic [5:0]       sync_ctl,
  output logic             pixel_strobe,
  output logic             link_up,
  // panel pins
  dpo_link_if.panel        link
);
  localparam int BW = 54;

  typedef struct packed {
    logic          pc_s1;
    logic          pc_s2;
    logic          pc_s3;
    logic [BW-1:0] bus_s1;
    logic [BW-1:0] bus_s2;
    logic          lnk_s1;
    logic          lnk_s2;
    logic [2:0]    cfg;
    logic          gate;
    logic [23:0]   ev;
    logic [23:0]   od;
    logic [5:0]    ctl;
    logic          stb;
  } dpo_pnl_st_t;
  dpo_pnl_st_t st_reg, st_next;

  // sync and capture on the selected latch edge
  always_comb begin
    logic latch;
    latch   = 1'b0;
    st_next = st_reg;
    st_next.pc_s1  = link.output_pixel_clock;
    st_next.pc_s2  = st_reg.pc_s1;
    st_next.pc_s3  = st_reg.pc_s2;
    st_next.bus_s1 = {link.active_video_enable, link.hsync, link.vsync,
                      link.control_bit_one, link.control_bit_two,
                      link.control_bit_three, link.odd_pixel_bus, link.even_pixel_bus};
    st_next.bus_s2 = st_reg.bus_s1;
    st_next.lnk_s1 = link.link_active_flag;
    st_next.lnk_s2 = st_reg.lnk_s1;
    st_next.cfg    = {latch_rising, skew_n, two_pixel_mode};
    // board option: flag drives the output power gate
    st_next.gate   = TIE_GATE ? st_reg.lnk_s2 : 1'b1; // RULE9
    latch = st_reg.cfg[2] ? (st_reg.pc_s2 && !st_reg.pc_s3)
                          : (!st_reg.pc_s2 && st_reg.pc_s3); // RULE14
    st_next.stb = latch;
    if (latch) begin
      st_next.ev  = st_reg.bus_s2[23:0];
      st_next.od  = st_reg.bus_s2[47:24];
      st_next.ctl = st_reg.bus_s2[53:48];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign link.pixels_per_clock_select = st_reg.cfg[0];
  assign link.skew_outputs_n          = st_reg.cfg[1];
  assign link.clock_edge_select       = st_reg.cfg[2];
  assign link.output_power_gate       = st_reg.gate;
  assign even_pixel   = st_reg.ev;
  assign odd_pixel    = st_reg.od;
  assign sync_ctl     = st_reg.ctl;
  assign pixel_strobe = st_reg.stb;
  assign link_up      = st_reg.lnk_s2;
endmodule
`default_nettype wire

// >>> sim/dpo_link_asserts.sv
// Purpose: pin-level checks on the link between receiver output end and panel end
// Assumes: sampled on the core clock, straps steady for 8 cycles around a pixel
// Notes:   launch and latch edges are found from the output clock's last level
`timescale 1ns/1ns
`default_nettype none
module dpo_link_asserts #(
  parameter int HALF1 = 6,
  parameter int HALF2 = 12
) (
  // core clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // device-driven pins
  input  wire logic [23:0] even_pixel_bus,
  input  wire logic [23:0] odd_pixel_bus,
  input  wire logic        output_pixel_clock,
  input  wire logic        active_video_enable,
  input  wire logic        link_active_flag,
  // panel-driven straps
  input  wire logic        pixels_per_clock_select,
  input  wire logic        skew_outputs_n,
  input  wire logic        clock_edge_select
);
  localparam int SKEW_OUTPUTS_N_DLY = HALF2 / 2 + 1;
  logic clk_reg;
  logic launch;
  logic latch;

  // -----------------------------------------------------------------
  // edge finder
  // -----------------------------------------------------------------
  // last output clock level; the pin is slow enough to see every edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clk_reg <= 1'b0;
    end else begin
      clk_reg <= output_pixel_clock;
    end
  end
  // launch leaves the latch level, latch returns to it
  assign launch = (output_pixel_clock != clk_reg) && (output_pixel_clock != clock_edge_select);
  assign latch  = (output_pixel_clock != clk_reg) && (output_pixel_clock == clock_edge_select);

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_even_at_launch: assert property ($changed(even_pixel_bus) |-> launch)
    else $error("even bus moved away from a launch edge");
  a_odd_bus_low: assert property ((!pixels_per_clock_select)[*8] ##0 launch |->
    odd_pixel_bus == 24'h000000)
    else $error("odd bus not low in one pixel mode");
  a_half_one: assert property ((!pixels_per_clock_select)[*8] ##0 launch |-> ##HALF1 latch)
    else $error("one pixel output clock phase wrong");
  a_half_two: assert property (pixels_per_clock_select[*8] ##0 launch |-> ##HALF2 latch)
    else $error("two pixel output clock phase wrong");
  a_odd_together: assert property ((pixels_per_clock_select && skew_outputs_n)[*8]
    ##0 $changed(odd_pixel_bus) |-> launch)
    else $error("odd bus not launched with even bus");
  a_odd_late: assert property ((pixels_per_clock_select && !skew_outputs_n)[*8]
    ##0 $changed(odd_pixel_bus) |-> $past(launch, SKEW_OUTPUTS_N_DLY))
    else $error("staggered odd bus at wrong offset");
  a_latch_stable: assert property (latch |-> $stable(even_pixel_bus) && $stable(odd_pixel_bus))
    else $error("pixel bus moved at the latch edge");
  a_blank_zero: assert property (launch && !active_video_enable |->
    even_pixel_bus == 24'h000000)
    else $error("blanking word carried pixel data");
  a_flag_rise: assert property ($rose(active_video_enable) |-> link_active_flag)
    else $error("video enable toggled with link flag low");

  // main scenarios reached
  c_one_pixel: cover property (launch && !pixels_per_clock_select);
  c_staggered: cover property (launch && pixels_per_clock_select && !skew_outputs_n);
  c_link_up: cover property ($rose(link_active_flag));
endmodule
`default_nettype wire

// >>> sim/dvi_pixel_output_formatter_tb.sv
// Purpose: receiver output end driving the panel end, pixels checked at the panel
// Assumes: gate not tied to the flag, so first pixels are not zeroed
// Notes:   lane clock runs only inside frames and the overflow run; overflow run comes last
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dvi_pixel_output_formatter_tb;
  localparam logic [2:0] MODES [7] = '{3'h3, 3'h2, 3'h7, 3'h5, 3'h4, 3'h6, 3'h1};
  logic        clock;
  logic        rstn;
  logic        clock_lane_input;
  logic [7:0]  lane_zero_input;
  logic [7:0]  lane_one_input;
  logic [7:0]  lane_two_input;
  logic        lane_enable_input;
  logic        two_pixel_mode;
  logic        skew_n;
  logic        latch_rising;
  logic [23:0] even_pixel;
  logic [23:0] odd_pixel;
  logic [5:0]  sync_ctl;
  logic        pixel_strobe;
  logic        link_up;
  logic        overflow;
  logic [53:0] exp_q[$];
  logic [53:0] want;
  logic [53:0] pend;     // even word waiting for its odd partner
  logic        pend_ok;
  logic [4:0]  held;     // control bits carried through active video
  logic        skip;     // no checking: buffer overrun or strap change
  int          n_fail;
  int          n_compared;

  dpo_link_if link_i ();
  dpo_rx_out #(.IDLE_CYC(200)) dpo_rx_out_i (
    .clock(clock), .rstn(rstn), .ce(1'b1), .clock_lane_input(clock_lane_input),
    .lane_zero_input(lane_zero_input), .lane_one_input(lane_one_input),
    .lane_two_input(lane_two_input), .lane_enable_input(lane_enable_input),
    .overflow(overflow), .link(link_i.dev));
  dpo_panel_sink #(.TIE_GATE(1'b0)) dpo_panel_sink_i (
    .clock(clock), .rstn(rstn), .ce(1'b1), .two_pixel_mode(two_pixel_mode),
    .skew_n(skew_n), .latch_rising(latch_rising), .even_pixel(even_pixel),
    .odd_pixel(odd_pixel), .sync_ctl(sync_ctl), .pixel_strobe(pixel_strobe),
    .link_up(link_up), .link(link_i.panel));
  dpo_link_asserts dpo_link_asserts_i (
    .clock(clock), .rstn(rstn), .even_pixel_bus(link_i.even_pixel_bus),
    .odd_pixel_bus(link_i.odd_pixel_bus), .output_pixel_clock(link_i.output_pixel_clock),
    .active_video_enable(link_i.active_video_enable),
    .link_active_flag(link_i.link_active_flag),
    .pixels_per_clock_select(link_i.pixels_per_clock_select),
    .skew_outputs_n(link_i.skew_outputs_n), .clock_edge_select(link_i.clock_edge_select));

  // 100 MHz core clock
  initial clock = 1'b0;
  always #5 clock = ~clock;

  // -----------------------------------------------------------------
  // closing
  // -----------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // -----------------------------------------------------------------
  // lane driver: notes the expected panel word, then clocks the lanes
  // -----------------------------------------------------------------
  task automatic send(input logic en, input logic [7:0] l0, input logic [7:0] l1,
                      input logic [7:0] l2);
    logic [53:0] e;
    lane_enable_input = en;
    lane_zero_input = l0;
    lane_one_input = l1;
    lane_two_input = l2;
    e[53:30] = en ? {l2, l1, l0} : 24'h000000;
    e[29:6] = 24'h000000;
    e[5:0] = en ? {1'b1, held} : {1'b0, l0[0], l0[1], l1[0], l2[0], l2[1]};
    if (!en) begin
      held = e[4:0];
    end
    if (!two_pixel_mode) begin
      exp_q.push_back(e);
    end else if (!pend_ok) begin
      pend = e;
      pend_ok = 1'b1;
    end else begin
      exp_q.push_back({pend[53:30], e[53:30], pend[5:0]});
      pend_ok = 1'b0;
    end
    #62 clock_lane_input = 1'b1;
    #63 clock_lane_input = 1'b0;
  endtask

  // blanking pair, n active words, blanking pair; then drain
  task automatic frame(input int n);
    logic [23:0] b;
    b = 24'($urandom);
    repeat (2) send(1'b0, b[7:0], b[15:8], b[23:16]);
    repeat (n) send(1'b1, 8'($urandom), 8'($urandom), 8'($urandom));
    `CHK(link_up, 1'b1)
    b = 24'($urandom);
    repeat (2) send(1'b0, b[7:0], b[15:8], b[23:16]);
    // released lanes must not look like the last word
    {lane_two_input, lane_one_input, lane_zero_input} = ~b;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clock);
    `CHK(exp_q.size(), 0)
    repeat (20) @(posedge clock);
  endtask

  // a strap change re-parks the output clock: that latch carries no pixel
  task automatic set_mode(input logic [2:0] m);
    @(posedge clock);
    #1 skip = 1'b1;
    {two_pixel_mode, skew_n, latch_rising} = m;
    repeat (10) @(posedge clock);
    #1 skip = 1'b0;
  endtask

  // oldest note against every latched pixel, away from the clock edge
  always @(negedge clock) begin
    if (pixel_strobe === 1'b1 && !skip) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        want = exp_q.pop_front();
        `CHK({even_pixel, odd_pixel, sync_ctl}, want)
      end
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(93466));
    {n_fail, n_compared} = '0;
    skip = 1'b1;
    {pend_ok, held, pend} = '0;
    {rstn, clock_lane_input, lane_enable_input} = '0;
    {lane_two_input, lane_one_input, lane_zero_input} = 24'h000000;
    {two_pixel_mode, skew_n, latch_rising} = 3'h3;
    repeat (16) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clock);
    `CHK(link_up, 1'b0)
    `CHK(link_i.odd_pixel_bus, 24'h000000)
    // seven of the eight strap combinations (all but 3'h0), one frame each
    foreach (MODES[i]) begin
      set_mode(MODES[i]);
      frame(4 + 2 * i);
    end
    // link idles out once enable stops toggling
    repeat (400) @(posedge clock);
    `CHK(link_up, 1'b0)
    `CHK(overflow, 1'b0)
    // one pixel out is slower than lanes in: buffer overruns
    set_mode(3'h3);
    skip = 1'b1;
    repeat (150) send(1'b1, 8'($urandom), 8'($urandom), 8'($urandom));
    repeat (5) @(posedge clock);
    `CHK(overflow, 1'b1)
    complete_run();
  end

  // hang guard, well past the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clock);
    n_fail++;
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
